//--- hw/vsp_pkg.sv
package vsp_pkg;
    // Clock rate in kHz, 125 MHz
    localparam int CLK_KHZ = 125000;
    // Evaluation period for the valley-select update, in ms
    localparam int EVAL_PERIOD_MS = 48;
    localparam int EVAL_CYCLES = EVAL_PERIOD_MS * CLK_KHZ;
    // Interval figures in ns, plain defaults
    localparam int SHORT_RS_NS = 2500;
    localparam int LONG_RS_NS = 25000;
    localparam int MAX_OFF_NS = 42000;
    localparam int MAX_ON_NS = 30000;
    localparam int LEB_NS = 220;
    localparam int SW_BLANK_NS = 190;
    localparam int OVP_BLANK_NS = 1000;
    // Cycle counts at 8 ns; clock in MHz keeps products inside int
    localparam int CLK_MHZ = CLK_KHZ / 1000;
    localparam int SHORT_RS_CYC = (SHORT_RS_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_RS_CYC = (LONG_RS_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_OFF_CYC = (MAX_OFF_NS * CLK_MHZ) / 1000;
    localparam int MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
    localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
    localparam int SW_BLANK_CYC = (SW_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int OVP_BLANK_CYC = (OVP_BLANK_NS * CLK_MHZ + 999) / 1000;
    // Counter limits and reset values
    localparam logic [2:0] VSEL_MIN = 3'h1;
    localparam logic [2:0] VSEL_MAX = 3'h7;
    localparam logic [2:0] VSEL_RESET = 3'h1;
    localparam logic [2:0] VCNT_MAX = 3'h7;
    localparam logic [2:0] VCNT_RESET = 3'h0;
    localparam int TW = 16;
    localparam int EW = 23;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic fb_low_threshold;
        logic fb_mid_threshold;
        logic fb_reset_threshold;
        logic valley_detect_level;
        logic output_overvoltage_level;
        logic ringing_select_level;
        logic pwm_trip;
        logic current_limit;
        logic short_winding_level;
    } vsp_cmp_type;

    typedef enum logic [1:0] {
        ST_SUPPRESS = 2'b00,
        ST_WAIT = 2'b01,
        ST_ON = 2'b10,
        ST_LATCHED = 2'b11
    } vsp_state_type;
endpackage

//--- hw/vsp_filter.sv
`timescale 1ns/1ps
// Passes a level only after it has held for LEN consecutive cycles
module vsp_filter
    import vsp_pkg::*;
#(
    parameter int LEN = 4
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic level,
    output logic fired
);
    logic [TW-1:0] cnt_q;

    // Counts consecutive active cycles, restarts on any gap
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            fired <= 1'b0;
        end
        else if (!enable || !level)
        begin
            cnt_q <= '0;
            fired <= 1'b0;
        end
        else if (cnt_q >= TW'(LEN - 1))
        begin
            fired <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

//--- hw/vsp_core.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Valley select held within one to seven
// RULE2 - Feedback judged per 48ms period, then updated
// RULE3 - Always below low threshold: count up
// RULE4 - Between low and mid: hold value
// RULE5 - Above mid, below reset: count down
// RULE6 - Above reset threshold: force to one
// RULE7 - Valley select starts at one
// RULE8 - Count valley crossings after turn-off, max seven
// RULE9 - Valley count cleared on gate rise
// RULE10 - Off-time overvoltage latches off after blanking
// RULE11 - Ringing level picks short or long suppression
// RULE12 - Gate held low during suppression
// RULE13 - Turn on when count reaches selection
// RULE14 - Maximum off-time forces turn-on
// RULE15 - PWM comparator trip turns gate off
// RULE16 - Blanking after turn-on ignores current comparators
// RULE17 - Maximum on-time forces turn-off
// RULE18 - Current limit after blanking turns off
// RULE19 - Short-winding flag filtered before latch-off
// RULE20 - Latch released only by supply drop
// RULE21 - Burst exit sets valley select to one
// RULE22 - Intervals held as clock cycle constants
module vsp_core
    import vsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_power_down,
    input wire logic burst_exit,
    input wire vsp_cmp_type cmp,
    output logic gate_drive,
    output logic latched_off,
    output logic [2:0] valley_select,
    output logic [2:0] valley_count
);
    logic rst_meta_q;
    logic rst_sync_q;
    vsp_state_type state_q;
    logic [TW-1:0] tmr_q;
    logic [TW-1:0] rs_len_q;
    logic [EW-1:0] eval_q;
    logic seen_low_q;
    logic seen_mid_q;
    logic valley_prev_q;
    logic ovp_fired;
    logic sw_fired;
    logic blanked;
    logic trip;
    logic valley_fall;

    // Saturating step within the valley-select range
    function automatic logic [2:0] vsel_step(input logic [2:0] v,
                                             input logic up);
        if (up)
            vsel_step = (v >= VSEL_MAX) ? VSEL_MAX : v + 3'h1;
        else
            vsel_step = (v <= VSEL_MIN) ? VSEL_MIN : v - 3'h1;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Derived conditions
    assign blanked = (state_q == ST_ON) && (tmr_q < TW'(LEB_CYC)); // see RULE16
    assign trip = !blanked && (cmp.pwm_trip || cmp.current_limit); // see RULE15
    assign valley_fall = valley_prev_q && !cmp.valley_detect_level;

    // Output overvoltage filter, active only during off-time
    vsp_filter #(.LEN(OVP_BLANK_CYC)) u_ovp (
        .clk(sys_clk),
        .rst_n(rst_sync_q),
        .enable(state_q == ST_SUPPRESS || state_q == ST_WAIT), // see RULE10
        .level(cmp.output_overvoltage_level),
        .fired(ovp_fired)
    );

    // Short-winding spike filter, active during on-time
    vsp_filter #(.LEN(SW_BLANK_CYC)) u_sw (
        .clk(sys_clk),
        .rst_n(rst_sync_q),
        .enable(state_q == ST_ON), // see RULE19
        .level(cmp.short_winding_level),
        .fired(sw_fired)
    );

    // Evaluation period timer and threshold memory
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            eval_q <= '0;
            seen_low_q <= 1'b0;
            seen_mid_q <= 1'b0;
        end
        else if (eval_q >= EW'(EVAL_CYCLES - 1)) // see RULE2
        begin
            eval_q <= '0;
            seen_low_q <= 1'b0;
            seen_mid_q <= 1'b0;
        end
        else
        begin
            eval_q <= eval_q + 1'b1;
            seen_low_q <= seen_low_q || cmp.fb_low_threshold;
            seen_mid_q <= seen_mid_q || cmp.fb_mid_threshold;
        end
    end

    // Valley-select up/down counter
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            valley_select <= VSEL_RESET; // see RULE7
        else if (cmp.fb_reset_threshold || burst_exit)
            valley_select <= VSEL_MIN; // see RULE6 see RULE21
        else if (eval_q >= EW'(EVAL_CYCLES - 1))
        begin
            if (seen_mid_q || cmp.fb_mid_threshold)
                valley_select <= vsel_step(valley_select, 1'b0); // see RULE5
            else if (!(seen_low_q || cmp.fb_low_threshold))
                valley_select <= vsel_step(valley_select, 1'b1); // see RULE3
            // Otherwise unchanged, see RULE4; range kept, see RULE1
        end
    end

    // Valley crossing counter
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            valley_count <= VCNT_RESET;
            valley_prev_q <= 1'b0;
        end
        else
        begin
            valley_prev_q <= cmp.valley_detect_level;
            if (state_q == ST_ON)
                valley_count <= VCNT_RESET; // see RULE9
            else if (valley_fall && valley_count < VCNT_MAX)
                valley_count <= valley_count + 3'h1; // see RULE8
        end
    end

    // Switching state machine; tmr_q counts on-time or off-time (suppression and wait together), held while latched
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= ST_SUPPRESS;
            tmr_q <= '0;
            rs_len_q <= TW'(LONG_RS_CYC);
        end
        else
        begin
            unique case (state_q)
                ST_SUPPRESS:
                begin
                    tmr_q <= tmr_q + 1'b1;
                    // Pick suppression once the gate is low and the pin free
                    if (tmr_q == TW'(1))
                        rs_len_q <= cmp.ringing_select_level ? // see RULE11
                            TW'(SHORT_RS_CYC) : TW'(LONG_RS_CYC);
                    if (ovp_fired)
                        state_q <= ST_LATCHED; // see RULE10
                    else if (tmr_q >= rs_len_q - 1'b1) // see RULE12
                        state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    tmr_q <= tmr_q + 1'b1;
                    if (ovp_fired)
                        state_q <= ST_LATCHED;
                    else if (valley_count >= valley_select // see RULE13
                             || tmr_q >= TW'(MAX_OFF_CYC - 1)) // see RULE14
                    begin
                        state_q <= ST_ON;
                        tmr_q <= '0;
                    end
                end
                ST_ON:
                begin
                    tmr_q <= tmr_q + 1'b1;
                    if (sw_fired)
                        state_q <= ST_LATCHED; // see RULE19
                    else if (trip || tmr_q >= TW'(MAX_ON_CYC - 1)) // see RULE17 see RULE18
                    begin
                        state_q <= ST_SUPPRESS;
                        tmr_q <= '0;
                    end
                end
                ST_LATCHED:
                begin
                    if (supply_power_down) // see RULE20
                    begin
                        state_q <= ST_SUPPRESS;
                        tmr_q <= '0;
                    end
                end
            endcase
        end
    end

    // Registered outputs (intervals are constants, see RULE22)
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            gate_drive <= 1'b0;
            latched_off <= 1'b0;
        end
        else
        begin
            gate_drive <= (state_q == ST_ON);
            latched_off <= (state_q == ST_LATCHED);
        end
    end

    // Checks
    a_gate_low_suppress: assert property (@(posedge sys_clk) // see RULE12
        disable iff (!rst_sync_q)
        state_q == ST_SUPPRESS |=> !gate_drive)
        else $error("gate high during suppression");
    a_select_range: assert property (@(posedge sys_clk) // see RULE1
        disable iff (!rst_sync_q)
        valley_select >= 3'h1 && valley_select <= 3'h7)
        else $error("valley select out of range");
    a_reset_force: assert property (@(posedge sys_clk) // see RULE6
        disable iff (!rst_sync_q)
        cmp.fb_reset_threshold |=> valley_select == 3'h1)
        else $error("reset threshold did not force one");
    a_count_clear: assert property (@(posedge sys_clk) // see RULE9
        disable iff (!rst_sync_q)
        $rose(gate_drive) |-> valley_count == 3'h0)
        else $error("valley count not cleared");
    a_leb_hold: assert property (@(posedge sys_clk) // see RULE16
        disable iff (!rst_sync_q)
        $rose(gate_drive) |-> gate_drive[*8])
        else $error("gate fell during blanking");
    a_max_on: assert property (@(posedge sys_clk) // see RULE17
        disable iff (!rst_sync_q)
        state_q == ST_ON && tmr_q == TW'(MAX_ON_CYC - 1) |=> state_q != ST_ON)
        else $error("max on time exceeded");
    a_max_off: assert property (@(posedge sys_clk) // see RULE14
        disable iff (!rst_sync_q)
        state_q == ST_WAIT && tmr_q >= TW'(MAX_OFF_CYC - 1) && !ovp_fired
        |=> state_q == ST_ON)
        else $error("max off time not honoured");
    a_latch_hold: assert property (@(posedge sys_clk) // see RULE20
        disable iff (!rst_sync_q)
        state_q == ST_LATCHED && !supply_power_down |=> state_q == ST_LATCHED)
        else $error("latch released without supply drop");
    a_trip_off: assert property (@(posedge sys_clk) // see RULE18
        disable iff (!rst_sync_q)
        state_q == ST_ON && trip && !sw_fired |=> state_q == ST_SUPPRESS)
        else $error("trip did not turn gate off");
    c_turn_on: cover property (@(posedge sys_clk) $rose(gate_drive));
    c_latch: cover property (@(posedge sys_clk) $rose(latched_off));
    c_select_up: cover property (@(posedge sys_clk) valley_select == 3'h7);
endmodule

//--- testbench/vsp_switch_model.sv
`timescale 1ns/1ps
// Switch and sensing network as seen from the controller pins
module vsp_switch_model
    import vsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic gate_drive,
    input wire logic use_limit,
    input wire logic ring_high,
    input var int trip_delay,
    input var int ring_period,
    output logic valley_detect_level,
    output logic ringing_select_level,
    output logic pwm_trip,
    output logic current_limit
);
    int on_cnt = 0;
    int off_cnt = 0;
    // Cycles since the last gate edge
    always_ff @(posedge sys_clk)
    begin
        on_cnt <= gate_drive ? on_cnt + 1 : 0;
        off_cnt <= gate_drive ? 0 : off_cnt + 1;
    end
    // Ringing only while off; pin clamped low during on-time
    assign valley_detect_level = !gate_drive && ring_period != 0 &&
        (off_cnt % ring_period) < ring_period / 2;
    assign ringing_select_level = !gate_drive && ring_high;
    // Current ramps until the chosen trip point
    assign pwm_trip = gate_drive && !use_limit && on_cnt >= trip_delay;
    assign current_limit = gate_drive && use_limit && on_cnt >= trip_delay;
endmodule

//--- testbench/tb_valley_switching_pwm_timing.sv
`timescale 1ns/1ps
// Self-checking bench for the switching decision core
module tb_valley_switching_pwm_timing;
    import vsp_pkg::*;
    logic sys_clk = 0;
    logic rst_n = 0;
    logic supply_power_down = 0;
    logic burst_exit = 0;
    logic fbr = 0;
    logic ovp = 0;
    logic sw = 0;
    logic lim = 0;
    logic rsh = 0;
    logic vd, rs, trp, cl, last;
    int trip = 100;
    int ring = 40;
    int num_errors = 0;
    int checks = 0;
    int n;
    vsp_cmp_type cmp;
    logic gate_drive, latched_off;
    logic [2:0] valley_select, valley_count;
    // Comparator flags, feedback held between low and mid
    assign cmp = '{1'b1, 1'b0, fbr, vd, ovp, rs, trp, cl, sw};
    always #4 sys_clk = ~sys_clk;
    vsp_core vsp_core_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .supply_power_down(supply_power_down),
        .burst_exit(burst_exit),
        .cmp(cmp),
        .gate_drive(gate_drive),
        .latched_off(latched_off),
        .valley_select(valley_select),
        .valley_count(valley_count)
    );
    vsp_switch_model vsp_switch_model_i (
        .sys_clk(sys_clk),
        .gate_drive(gate_drive),
        .use_limit(lim),
        .ring_high(rsh),
        .trip_delay(trip),
        .ring_period(ring),
        .valley_detect_level(vd),
        .ringing_select_level(rs),
        .pwm_trip(trp),
        .current_limit(cl)
    );
    // Inputs change one ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %0h not %0h", $time, seen, exp);
        end
    endtask
    function automatic logic in(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    // Cycles until the gate shows the wanted level, bounded
    task automatic wait_gate(input logic v);
        n = 0;
        while (gate_drive !== v && n < 9000)
        begin
            last = valley_count != 3'h0;
            tick(1);
            n++;
        end
    endtask
    task automatic t_cycles;
        wait_gate(1);
        check(in(n, 3125, 3185), 1);
        check(last, 1);
        rsh = 1;
        tick(2);
        check(valley_count, VCNT_RESET);
        wait_gate(0);
        check(in(n, 98, 106), 1);
        trip = 0;
        wait_gate(1);
        check(in(n, 313, 365), 1);
        wait_gate(0);
        check(in(n, 27, 33), 1);
        rsh = 0;
        lim = 1;
        trip = 50;
        wait_gate(1);
        wait_gate(0);
        check(in(n, 48, 56), 1);
        lim = 0;
        trip = 100000;
        ring = 0;
        wait_gate(1);
        check(in(n, 5245, 5256), 1);
        wait_gate(0);
        check(in(n, 3745, 3756), 1);
        $display("cycle timing test done");
    endtask
    task automatic release_latch;
        supply_power_down = 1;
        tick(1);
        supply_power_down = 0;
        tick(3);
        check(latched_off, 0);
    endtask
    task automatic t_short_wind;
        ring = 40;
        wait_gate(1);
        sw = 1;
        tick(10);
        sw = 0;
        tick(3);
        check(latched_off, 0);
        sw = 1;
        tick(40);
        sw = 0;
        tick(3);
        check({latched_off, gate_drive}, 2'b10);
        tick(6000);
        check({latched_off, gate_drive}, 2'b10);
        release_latch();
        $display("short winding test done");
    endtask
    task automatic t_ovp;
        ovp = 1;
        tick(50);
        ovp = 0;
        tick(3);
        check(latched_off, 0);
        ovp = 1;
        tick(200);
        ovp = 0;
        tick(3);
        check({latched_off, gate_drive}, 2'b10);
        release_latch();
        $display("overvoltage test done");
    endtask
    task automatic t_select;
        fbr = 1;
        tick(3);
        check(valley_select, VSEL_MIN);
        fbr = 0;
        burst_exit = 1;
        tick(1);
        burst_exit = 0;
        tick(3);
        check(valley_select, VSEL_RESET);
        $display("valley select test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence: reset for 8 cycles, then the scenarios
    initial
    begin
        tick(8);
        check({gate_drive, latched_off}, 2'b00);
        check(valley_select, VSEL_RESET);
        check(valley_count, VCNT_RESET);
        rst_n = 1;
        t_cycles();
        t_short_wind();
        t_ovp();
        t_select();
        wrap_up();
    end
    // Cuts a hang short well past the expected run length
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        wrap_up();
    end
endmodule
